//--- src/laie_line_alarm_irq_enable.sv
`timescale 1ns/100ps
`include "laie_regs.svh"
module laie_line_alarm_irq_enable #(
  parameter int NUM_CH = 3
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`LAIE_ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire laie_pkg::laie_byte_type regWdata,
  output laie_pkg::laie_byte_type regRdata,
  output logic regHit,
  input wire logic [NUM_CH-1:0] fifo_limit_alarm,
  input wire logic [NUM_CH-1:0] receive_lock_loss,
  input wire logic [NUM_CH-1:0] receive_signal_loss,
  input wire logic [NUM_CH-1:0] drive_monitor_output,
  output logic [NUM_CH-1:0] chanIrq
);
  // Only three channels have slots in the register map
  if (NUM_CH < 1 || NUM_CH > 3) begin : gBadNumCh
    $error("NUM_CH must be 1 to 3");
  end

  // Bus strobes and write field
  logic wrStrobe;
  logic rdStrobe;
  laie_pkg::laie_cond_type wrField;

  // Address decode, per channel and combined over all channels
  logic [NUM_CH-1:0] enaSel;
  logic [NUM_CH-1:0] stsSel;
  logic [NUM_CH-1:0] enaWrite;
  logic [NUM_CH-1:0] stsRead;
  logic anyEnaSel;
  logic anyStsSel;
  logic mappedSel;

  // Per-channel state
  laie_pkg::laie_cond_type ena_reg [NUM_CH];
  laie_pkg::laie_cond_type ena_next [NUM_CH];
  laie_pkg::laie_cond_type sts_reg [NUM_CH];
  laie_pkg::laie_cond_type sts_next [NUM_CH];
  laie_pkg::laie_cond_type cond_reg [NUM_CH];
  laie_pkg::laie_cond_type cond_next [NUM_CH];

  // Per-channel change detection
  laie_pkg::laie_cond_type condEdge [NUM_CH];
  laie_pkg::laie_cond_type condHit [NUM_CH];
  laie_pkg::laie_cond_type stsKeep [NUM_CH];

  // Read path
  laie_pkg::laie_byte_type enaView [NUM_CH];
  laie_pkg::laie_byte_type stsView [NUM_CH];
  laie_pkg::laie_byte_type chanView [NUM_CH];
  laie_pkg::laie_byte_type rdMux [NUM_CH+1];
  laie_pkg::laie_byte_type rdData_next;
  laie_pkg::laie_byte_type rdData_reg;
  logic hit_next;
  logic hit_reg;

  assign wrStrobe = regWrite;
  assign rdStrobe = regRead;
  // Only the low nibble is kept, so bits 7 to 4 can never be written
  assign wrField = regWdata[3:0];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : gCh
      // Channels sit one stride apart in the map
      assign enaSel[ch] = regAddr == `LAIE_ENA_CH0 + 6'(ch * `LAIE_CH_STRIDE);
      assign stsSel[ch] = regAddr == `LAIE_STS_CH0 + 6'(ch * `LAIE_CH_STRIDE);
      assign enaWrite[ch] = wrStrobe && enaSel[ch];
      assign stsRead[ch] = rdStrobe && stsSel[ch];

      assign cond_next[ch][`LAIE_BIT_FIFO_LIM] = fifo_limit_alarm[ch];
      assign cond_next[ch][`LAIE_BIT_LOCK_LOSS] = receive_lock_loss[ch];
      assign cond_next[ch][`LAIE_BIT_SIG_LOSS] = receive_signal_loss[ch];
      assign cond_next[ch][`LAIE_BIT_DRV_MON] = drive_monitor_output[ch];

      // Rise and fall both count, so a plain difference is enough
      assign condEdge[ch] = cond_next[ch] ^ cond_reg[ch];
      assign condHit[ch] = condEdge[ch] & ena_reg[ch];

      assign stsKeep[ch] = stsRead[ch] ? `LAIE_RESET_VAL : sts_reg[ch];
      // A new change beats the clear from a read in the same cycle
      assign sts_next[ch] = stsKeep[ch] | condHit[ch];
      assign ena_next[ch] = enaWrite[ch] ? wrField : ena_reg[ch];

      assign enaView[ch] = {4'h0, ena_reg[ch]};
      assign stsView[ch] = {4'h0, sts_reg[ch]};
      assign chanView[ch] = (enaSel[ch] ? enaView[ch] : 8'h00)
                            | (stsSel[ch] ? stsView[ch] : 8'h00);
      assign rdMux[ch+1] = rdMux[ch] | chanView[ch];
      // Level output: stays up until software reads the status register
      assign chanIrq[ch] = |sts_reg[ch];

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          ena_reg[ch] <= `LAIE_RESET_VAL;
        end else begin
          ena_reg[ch] <= ena_next[ch];
        end
      end

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          sts_reg[ch] <= `LAIE_RESET_VAL;
        end else begin
          sts_reg[ch] <= sts_next[ch];
        end
      end

      // History resets low; enables are clear then, so no false change follows reset
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          cond_reg[ch] <= `LAIE_RESET_VAL;
        end else begin
          cond_reg[ch] <= cond_next[ch];
        end
      end
    end
  endgenerate

  assign rdMux[0] = 8'h00;
  assign anyEnaSel = |enaSel;
  assign anyStsSel = |stsSel;
  assign mappedSel = anyEnaSel || anyStsSel;
  // Unmapped reads and idle cycles return zero rather than a stale byte
  assign rdData_next = rdStrobe ? rdMux[NUM_CH] : 8'h00;
  assign hit_next = rdStrobe && mappedSel;

  // Read data registered so it holds stable for the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  assign regRdata = rdData_reg;
  assign regHit = hit_reg;
endmodule : laie_line_alarm_irq_enable

//--- src/laie_pkg.sv
package laie_pkg;
  typedef logic [3:0] laie_cond_type;
  typedef logic [7:0] laie_byte_type;
endpackage : laie_pkg

//--- src/laie_regs.svh
`ifndef LAIE_REGS_SVH
`define LAIE_REGS_SVH
`define LAIE_ADDR_W 6
`define LAIE_ENA_CH0 6'h01
`define LAIE_ENA_CH1 6'h09
`define LAIE_ENA_CH2 6'h11
`define LAIE_STS_CH0 6'h02
`define LAIE_STS_CH1 6'h0A
`define LAIE_STS_CH2 6'h12
`define LAIE_CH_STRIDE 6'h08
`define LAIE_BIT_DRV_MON 0
`define LAIE_BIT_SIG_LOSS 1
`define LAIE_BIT_LOCK_LOSS 2
`define LAIE_BIT_FIFO_LIM 3
`define LAIE_FIELD_MASK 8'h0F
`define LAIE_RESET_VAL 4'h0
`endif

//--- testbench/laie_chk_assertions.sv
`timescale 1ns/100ps
`include "laie_regs.svh"
module laie_chk #(
  parameter int NUM_CH = 3
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regHit,
  input wire logic [`LAIE_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [NUM_CH-1:0] fifo_limit_alarm,
  input wire logic [NUM_CH-1:0] receive_lock_loss,
  input wire logic [NUM_CH-1:0] receive_signal_loss,
  input wire logic [NUM_CH-1:0] drive_monitor_output,
  input wire logic [NUM_CH-1:0] chanIrq
);
  logic [3:0] ena_reg, prv_reg;
  wire [3:0] cur = {fifo_limit_alarm[0], receive_lock_loss[0], receive_signal_loss[0],
    drive_monitor_output[0]};
  wire [3:0] h = ena_reg & (cur ^ prv_reg);
  wire eWr = regWrite && regAddr == `LAIE_ENA_CH0;
  wire eRd = regRead && regAddr == `LAIE_ENA_CH0;
  wire sRd = regRead && regAddr == `LAIE_STS_CH0;
  // Shadow of channel 0 enables, so the checker knows which changes must land
  always_ff @(posedge clk_sys or negedge nrst) if (!nrst) {ena_reg, prv_reg} <= 8'h00;
    else {ena_reg, prv_reg} <= {eWr ? regWdata[3:0] : ena_reg, cur};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_FIFO_LIM: assert property (h[3] |=> chanIrq[0]) else $error("irq");
  AST_LOCK_LOSS: assert property (h[2] |=> chanIrq[0]) else $error("irq");
  AST_SIG_LOSS: assert property (h[1] |=> chanIrq[0]) else $error("irq");
  AST_DRV_MON: assert property (h[0] |=> chanIrq[0]) else $error("irq");
  AST_CLR: assert property (sRd && h == 4'h0 |=> !chanIrq[0]) else $error("clr");
  AST_STS: assert property (sRd |=> regHit && (regRdata != 8'h00) == $past(chanIrq[0]))
    else $error("sts");
  AST_TOP: assert property (regRead |=> regRdata[7:4] == 4'h0) else $error("top");
  AST_RB: assert property (eWr ##1 eRd && !regWrite |=>
    regRdata == ($past(regWdata, 2) & `LAIE_FIELD_MASK)) else $error("rb");
  cover property (h != 4'h0);
  cover property (eWr ##1 eRd);
  cover property (sRd ##1 regRdata != 8'h00);
  cover property (sRd && h != 4'h0);
endmodule : laie_chk
bind laie_line_alarm_irq_enable laie_chk #(.NUM_CH(NUM_CH)) i_chk (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .regWrite(regWrite),
  .regRead(regRead),
  .regHit(regHit),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regRdata(regRdata),
  .fifo_limit_alarm(fifo_limit_alarm),
  .receive_lock_loss(receive_lock_loss),
  .receive_signal_loss(receive_signal_loss),
  .drive_monitor_output(drive_monitor_output),
  .chanIrq(chanIrq)
);

//--- testbench/laie_tb.sv
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'h0, nrst = 1'h0, regWrite = 1'h0, regRead = 1'h0, regHit;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [11:0] cond = 12'h000;
  logic [2:0] chanIrq;
  logic [15:0] lf = 16'h0060;
  int failures = 0, testsRun = 0, cyc = 0, eRd = 0, eIrq = 0, ena[3], sts[3], prv[3], h;
  laie_line_alarm_irq_enable i_dut (.clk_sys, .nrst, .regAddr, .regWrite, .regRead, .regWdata,
    .regRdata, .regHit, .fifo_limit_alarm(cond[11:9]), .receive_lock_loss(cond[8:6]),
    .receive_signal_loss(cond[5:3]), .drive_monitor_output(cond[2:0]), .chanIrq);
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  task automatic chk_rd(int e, logic [7:0] g);
    testsRun++;
    if (g !== 8'(e)) begin
      failures++;
      $display("[ERR] %0t rd %h %h", $time, 8'(e), g);
    end
  endtask : chk_rd
  task automatic chk_hit(int e, logic g);
    testsRun++;
    if (g !== 1'(e)) begin
      failures++;
      $display("[ERR] %0t hit %h %h", $time, 1'(e), g);
    end
  endtask : chk_hit
  task automatic chk_irq(int e, logic [2:0] g);
    testsRun++;
    if (g !== 3'(e)) begin
      failures++;
      $display("[ERR] %0t irq %h %h", $time, 3'(e), g);
    end
  endtask : chk_irq
  task automatic final_report;
    if (failures == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'h1;
    repeat (3000) @(posedge clk_sys);
    final_report;
  end
  always @(negedge clk_sys) if (nrst) begin
    chk_rd(eRd, regRdata);
    chk_hit(eRd >> 8, regHit);
    chk_irq(eIrq, chanIrq);
  end
  always @(posedge clk_sys) begin
    if (++cyc == 4000) begin
      failures++;
      final_report;
    end else if (nrst) begin
      eRd = 0;
      eIrq = 0;
      for (int c = 0; c < 3; c++) begin
        h = prv[c];
        prv[c] = {cond[9 + c], cond[6 + c], cond[3 + c], cond[c]};
        h = ena[c] & (h ^ prv[c]);
        if (regRead && regAddr == 8 * c + 1) eRd = ena[c] + 256;
        if (regRead && regAddr == 8 * c + 2) eRd = sts[c] + 256;
        if (regRead && regAddr == 8 * c + 2) sts[c] = 0;
        sts[c] |= h;
        if (regWrite && regAddr == 8 * c + 1) ena[c] = regWdata & 15;
        if (sts[c] != 0) eIrq += 1 << c;
      end
      // Few addresses, so mapped, unmapped and back-to-back accesses all recur
      lf = nx(lf);
      regAddr <= 6'(8 * lf[5:4] + lf[1:0]);
      {regWrite, regRead} <= lf[3:2];
      regWdata <= lf[15:8];
      if (lf[7]) cond <= lf[15:4];
    end
  end
endmodule : tb
